// ===== design/stw_pkg.sv
// shared constants and types of the supply threshold wake logic
package stw_pkg;
  // wishbone geometry
  localparam int unsigned STW_AW = 4;
  localparam int unsigned STW_DW = 32;
  // register byte offsets
  localparam logic [3:0] STW_OFF_STATUS = 4'h0; // supply_status_reg
  localparam logic [3:0] STW_OFF_DETECT = 4'h4; // supply_detect_ctrl_reg
  localparam logic [3:0] STW_OFF_IRQ    = 4'h8; // threshold_irq_reg
  localparam logic [3:0] STW_OFF_CLOCK  = 4'hC; // system_clock_ctrl_reg
  // field positions
  localparam int unsigned STW_B_ABOVE    = 0; // status: above_threshold_status
  localparam int unsigned STW_B_DET_EN   = 0; // detect: detector_enable
  localparam int unsigned STW_B_IRQ_EN   = 0; // irq: detect_irq_enable
  localparam int unsigned STW_B_EXIT_EN  = 1; // irq: stop_exit_enable
  localparam int unsigned STW_B_CROSS    = 2; // irq: crossing_flag
  localparam int unsigned STW_B_PEND     = 3; // irq: request pending (read only)
  localparam int unsigned STW_B_STOP_REQ = 0; // clock: stop_request
  localparam int unsigned STW_B_IN_WAIT  = 1; // clock: wait mode (read only)
  // reset values
  localparam logic STW_RST_DET_EN  = 1'b0;
  localparam logic STW_RST_IRQ_EN  = 1'b0;
  localparam logic STW_RST_EXIT_EN = 1'b0;
  localparam logic STW_RST_CROSS   = 1'b0;
  localparam logic [31:0] STW_RD_ZERO = 32'h0000_0000;

  // software control bits that travel together
  typedef struct packed {
    logic detector_enable;
    logic detect_irq_enable;
    logic stop_exit_enable;
  } stw_ctrl_t;

  // core power mode
  typedef enum logic [1:0] {
    STW_RUN,
    STW_STOP,
    STW_WAIT
  } stw_mode_t;
endpackage

// ===== design/stw_sync2.sv
// two flip-flop synchroniser for the comparator level
`timescale 1ns/1ps
module stw_sync2 (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_ff;
  logic nxt_meta;
  logic sync_ff;
  logic nxt_sync;

  // second stage only reads the first
  always_comb begin
    nxt_meta = async_i;
    nxt_sync = meta_ff;
  end

  // register both stages
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_o = sync_ff;
endmodule // stw_sync2

// ===== design/stw_wake.sv
// supply threshold detection interrupt and low-power wake control
// Summary of operation
// - In stop with the exit enable armed, supply above threshold raises the irq at once.
// - That stop wake needs detector, above status, irq enable, stop request and exit arming all at 1.
// - A wait instruction with detector, above status and irq enable at 1 wakes at once.
// - Stop requested above threshold with wake armed is left straight away.
// - Low power entered below threshold holds until the supply rises and the irq wakes.
// - Each crossing sets the flag, and outside stop only a 0-to-1 flag change or a wait wake raises irq.
// - Writing 0 to the crossing flag clears it and writing 1 leaves it alone.
`timescale 1ns/1ps
module stw_wake
  import stw_pkg::*;
(
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // wishbone classic slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [stw_pkg::STW_AW-1:0] wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [stw_pkg::STW_DW-1:0] wb_dat_i,
  output logic      [stw_pkg::STW_DW-1:0] wb_dat_o,
  output logic                          wb_ack_o,
  // analog comparator, asynchronous
  input  wire logic                     cmp_above_i,
  // core side
  input  wire logic                     wait_exec_i,
  input  wire logic                     irq_ack_i,
  output logic                          detect_irq_o,
  output logic                          stop_mode_o,
  output logic                          wait_mode_o
);
  import stw_pkg::*;

  logic      cmp_sync;
  stw_ctrl_t ctrl_ff;
  stw_ctrl_t nxt_ctrl;
  logic      armed_ff;
  logic      nxt_armed;
  logic      cross_ff;
  logic      nxt_cross;
  logic      prev_above_ff;
  logic      nxt_prev_above;
  logic      pend_ff;
  logic      nxt_pend;
  stw_mode_t mode_ff;
  stw_mode_t nxt_mode;
  logic      ack_ff;
  logic      nxt_ack;
  logic [STW_DW-1:0] dat_ff;
  logic [STW_DW-1:0] nxt_dat;
  logic      above;
  logic      req;
  logic      wr_lane;
  logic      wr_detect;
  logic      wr_irq;
  logic      wr_clock;
  logic      cross_evt;
  logic      stop_case;
  logic      wait_case;
  logic      edge_irq;

  // decode one register hit for a taken access
  function automatic logic hit(input logic [STW_AW-1:0] adr, input logic [3:0] off);
    hit = (adr == off);
  endfunction

  stw_sync2 u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (cmp_above_i),
    .sync_o  (cmp_sync)
  );

  // status and event terms
  always_comb begin
    above     = ctrl_ff.detector_enable ? cmp_sync : 1'b1; // reads 1 when detector off
    req       = wb_cyc_i & wb_stb_i & ~ack_ff;
    wr_lane   = req & wb_we_i & wb_sel_i[0];
    wr_detect = wr_lane & hit(wb_adr_i, STW_OFF_DETECT);
    wr_irq    = wr_lane & hit(wb_adr_i, STW_OFF_IRQ);
    wr_clock  = wr_lane & hit(wb_adr_i, STW_OFF_CLOCK);
    // last cycle's level is the reference, so each crossing is a one-cycle pulse
    cross_evt = ctrl_ff.detector_enable & (cmp_sync != prev_above_ff);
    stop_case = (mode_ff == STW_STOP) & armed_ff & ctrl_ff.detector_enable
              & above & ctrl_ff.detect_irq_enable;
    wait_case = (mode_ff == STW_RUN) & wait_exec_i & ctrl_ff.detector_enable
              & above & ctrl_ff.detect_irq_enable;
    edge_irq  = cross_evt & ~cross_ff & ctrl_ff.detect_irq_enable;
  end

  // control bits, exit arming, crossing flag and request
  always_comb begin
    nxt_ctrl       = ctrl_ff;
    nxt_armed      = armed_ff;
    nxt_prev_above = cmp_sync;
    if (wr_detect) begin
      nxt_ctrl.detector_enable = wb_dat_i[STW_B_DET_EN];
    end
    if (wr_irq) begin
      nxt_ctrl.detect_irq_enable = wb_dat_i[STW_B_IRQ_EN];
      nxt_ctrl.stop_exit_enable  = wb_dat_i[STW_B_EXIT_EN];
      if (wb_dat_i[STW_B_EXIT_EN] & ~ctrl_ff.stop_exit_enable) begin
        nxt_armed = 1'b1;
      end
    end
    // every wake disarms; the bit itself stays set until software rewrites it
    if ((mode_ff != STW_RUN) && (nxt_mode == STW_RUN)) begin
      nxt_armed = 1'b0;
    end
    // set wins over software clear; disabling the detector clears
    if (!ctrl_ff.detector_enable) begin
      nxt_cross = 1'b0;
    end else if (cross_evt) begin
      nxt_cross = 1'b1;
    end else if (wr_irq && !wb_dat_i[STW_B_CROSS]) begin
      nxt_cross = 1'b0;
    end else begin
      nxt_cross = cross_ff;
    end
    // request stays until acknowledged; a new cause wins over the ack
    if (stop_case || wait_case || edge_irq) begin
      nxt_pend = 1'b1;
    end else if (irq_ack_i) begin
      nxt_pend = 1'b0;
    end else begin
      nxt_pend = pend_ff;
    end
  end

  // power mode sequencing
  // stop exit needs the arming as well, wait exit only the pending request
  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      STW_RUN: begin
        if (wr_clock && wb_dat_i[STW_B_STOP_REQ]) begin
          nxt_mode = STW_STOP;
        end else if (wait_exec_i) begin
          nxt_mode = STW_WAIT;
        end
      end
      STW_STOP: begin
        if (pend_ff && armed_ff) begin
          nxt_mode = STW_RUN;
        end
      end
      STW_WAIT: begin
        if (pend_ff) begin
          nxt_mode = STW_RUN;
        end
      end
      default: begin
        nxt_mode = STW_RUN;
      end
    endcase
  end

  // wishbone answer, registered: ack and read data one cycle after the strobe
  always_comb begin
    nxt_ack = req;
    nxt_dat = STW_RD_ZERO;
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        STW_OFF_STATUS: nxt_dat[STW_B_ABOVE] = above;
        STW_OFF_DETECT: nxt_dat[STW_B_DET_EN] = ctrl_ff.detector_enable;
        STW_OFF_IRQ: begin
          nxt_dat[STW_B_IRQ_EN]  = ctrl_ff.detect_irq_enable;
          nxt_dat[STW_B_EXIT_EN] = ctrl_ff.stop_exit_enable;
          nxt_dat[STW_B_CROSS]   = cross_ff;
          nxt_dat[STW_B_PEND]    = pend_ff;
        end
        STW_OFF_CLOCK: begin
          nxt_dat[STW_B_STOP_REQ] = (mode_ff == STW_STOP);
          nxt_dat[STW_B_IN_WAIT]  = (mode_ff == STW_WAIT);
        end
        default: nxt_dat = STW_RD_ZERO;
      endcase
    end
  end

  // register all state except the pin flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff       <= '{STW_RST_DET_EN, STW_RST_IRQ_EN, STW_RST_EXIT_EN};
      armed_ff      <= 1'b0;
      cross_ff      <= STW_RST_CROSS;
      prev_above_ff <= 1'b0;
      pend_ff       <= 1'b0;
      mode_ff       <= STW_RUN;
      ack_ff        <= 1'b0;
      dat_ff        <= STW_RD_ZERO;
    end else begin
      ctrl_ff       <= nxt_ctrl;
      armed_ff      <= nxt_armed;
      cross_ff      <= nxt_cross;
      prev_above_ff <= nxt_prev_above;
      pend_ff       <= nxt_pend;
      mode_ff       <= nxt_mode;
      ack_ff        <= nxt_ack;
      dat_ff        <= nxt_dat;
    end
  end

  // outputs straight from flip-flops
  logic stop_ff;
  logic nxt_stop;
  logic wait_ff;
  logic nxt_wait;

  // pin flags follow the next mode so they line up with mode_ff
  always_comb begin
    nxt_stop = (nxt_mode == STW_STOP);
    nxt_wait = (nxt_mode == STW_WAIT);
  end

  // register the pin flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stop_ff <= 1'b0;
      wait_ff <= 1'b0;
    end else begin
      stop_ff <= nxt_stop;
      wait_ff <= nxt_wait;
    end
  end

  assign wb_ack_o     = ack_ff;
  assign wb_dat_o     = dat_ff;
  assign detect_irq_o = pend_ff;
  assign stop_mode_o  = stop_ff;
  assign wait_mode_o  = wait_ff;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_stop_wake_irq: assert property (
    stop_case |=> detect_irq_o ##1 !stop_mode_o)
    else $error("stop above threshold did not raise irq and leave stop");
  chk_stop_four_cond: assert property (
    (mode_ff == STW_STOP && !pend_ff && !cross_evt && !(armed_ff && above
      && ctrl_ff.detector_enable && ctrl_ff.detect_irq_enable)) |=> !detect_irq_o)
    else $error("stop irq raised without all conditions");
  chk_stop_leave: assert property (
    (mode_ff == STW_STOP && pend_ff && armed_ff) |=> (mode_ff == STW_RUN) && !stop_mode_o)
    else $error("armed stop with pending irq not left");
  chk_stop_hold: assert property (
    (mode_ff == STW_STOP && !pend_ff) |=> (mode_ff == STW_STOP))
    else $error("stop left without irq");
  chk_wait_wake: assert property (
    wait_case |=> detect_irq_o && wait_mode_o ##1 !wait_mode_o)
    else $error("wait above threshold not left at once");
  chk_wake_disarm: assert property (
    (mode_ff == STW_RUN && $past(mode_ff) != STW_RUN) |-> !armed_ff)
    else $error("exit enable still armed after wake");
  chk_flag_edge_irq: assert property (
    edge_irq |=> cross_ff && detect_irq_o)
    else $error("crossing edge did not set flag and irq");
  chk_flag_clear: assert property (
    (wr_irq && !wb_dat_i[STW_B_CROSS] && !cross_evt) |=> !cross_ff)
    else $error("writing 0 did not clear crossing flag");
  chk_irq_held: assert property (
    (pend_ff && !irq_ack_i) |=> detect_irq_o [*1] ##0 pend_ff)
    else $error("irq dropped before acknowledge");

  // mode entry checks
  chk_stop_entry: assert property (
    (mode_ff == STW_RUN && wr_clock && wb_dat_i[STW_B_STOP_REQ]) |=> stop_mode_o)
    else $error("stop request write did not enter stop");
  chk_wait_entry: assert property (
    (mode_ff == STW_RUN && wait_exec_i && !(wr_clock && wb_dat_i[STW_B_STOP_REQ]))
      |=> wait_mode_o)
    else $error("wait instruction did not enter wait");

  // crossing flag checks
  chk_flag_set_wins: assert property (
    cross_evt |=> cross_ff)
    else $error("crossing did not set the flag");
  chk_flag_keep_one: assert property (
    (wr_irq && wb_dat_i[STW_B_CROSS] && cross_ff && ctrl_ff.detector_enable) |=> cross_ff)
    else $error("writing 1 changed the crossing flag");
  chk_flag_no_irq: assert property (
    (mode_ff != STW_STOP && cross_evt && cross_ff && !pend_ff && !wait_case)
      |=> !detect_irq_o)
    else $error("crossing with flag set raised irq");

  // hold and release checks
  chk_wait_hold: assert property (
    (mode_ff == STW_WAIT && !pend_ff) |=> (mode_ff == STW_WAIT))
    else $error("wait left without irq");
  chk_stop_unarmed: assert property (
    (mode_ff == STW_STOP && !armed_ff) |=> stop_mode_o)
    else $error("stop left without rearmed exit");
  chk_irq_ack_drop: assert property (
    (pend_ff && irq_ack_i && !stop_case && !wait_case && !edge_irq)
      |=> !detect_irq_o)
    else $error("acknowledged irq still held");
endmodule // stw_wake

// ===== test/stw_partner.sv
// model of the supply comparator and of the core that acknowledges wakes
`timescale 1ns/1ps
module stw_partner (
  input  wire logic       clk_i,
  input  wire logic       supply_hi_i,
  input  wire logic [3:0] ack_dly_i,
  input  wire logic       detect_irq_i,
  output logic            cmp_above_o,
  output logic            irq_ack_o
);
  logic [3:0] cnt_ff = 4'h0;
  logic [3:0] nxt_cnt;
  logic       ack_ff = 1'b0;
  logic       nxt_ack;
  // comparator level follows the supply
  assign cmp_above_o = supply_hi_i;
  // core answers a held request after a chosen delay
  always_comb begin
    nxt_cnt = cnt_ff + 4'h1;
    nxt_ack = 1'b0;
    if (!detect_irq_i || ack_ff) begin
      nxt_cnt = 4'h0;
    end else if (cnt_ff == ack_dly_i) begin
      nxt_ack = 1'b1;
      nxt_cnt = cnt_ff;
    end
  end
  // registers only
  always_ff @(posedge clk_i) begin
    cnt_ff <= nxt_cnt;
    ack_ff <= nxt_ack;
  end
  assign irq_ack_o = ack_ff;
endmodule // stw_partner

// ===== test/test_stw_wake.sv
// self-checking testbench of the supply threshold wake logic
`timescale 1ns/1ps
module test_stw_wake;
  import stw_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h0, ack_dly = 4'h8;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic        wb_ack_o, cmp_above_i, irq_ack_i, wait_exec_i = 1'b0;
  logic        detect_irq_o, stop_mode_o, wait_mode_o, supply_hi = 1'b0;
  int          n_mismatch = 0, comparisons = 0;
  // free-running bus clock
  always #50 clk_i = ~clk_i;
  stw_wake uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmp_above_i(cmp_above_i),
    .wait_exec_i(wait_exec_i), .irq_ack_i(irq_ack_i), .detect_irq_o(detect_irq_o),
    .stop_mode_o(stop_mode_o), .wait_mode_o(wait_mode_o));
  stw_partner far (.clk_i(clk_i), .supply_hi_i(supply_hi), .ack_dly_i(ack_dly),
    .detect_irq_i(detect_irq_o), .cmp_above_o(cmp_above_i), .irq_ack_o(irq_ack_i));
  // verdict and end of run
  task automatic summarize;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic wishbone cycle, read data lands in rd
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) begin
      if (n == 20) begin
        n_mismatch++;
        summarize;
      end
      @(posedge clk_i);
      n++;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
    chk({31'h0, wb_ack_o}, 32'h0);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // bounded wait for {irq, stop, wait} outputs
  task automatic wait_out(input logic [2:0] exp, input int mx);
    int n;
    n = 0;
    while ({detect_irq_o, stop_mode_o, wait_mode_o} !== exp && n < mx) begin
      @(negedge clk_i);
      n++;
    end
    chk({29'h0, detect_irq_o, stop_mode_o, wait_mode_o}, {29'h0, exp});
  endtask
  task automatic hold(input logic [2:0] exp, input int k);
    repeat (k) begin
      @(negedge clk_i);
      chk({29'h0, detect_irq_o, stop_mode_o, wait_mode_o}, {29'h0, exp});
    end
  endtask
  task automatic supply(input logic v);
    @(posedge clk_i);
    supply_hi <= v;
  endtask
  task automatic pulse_wait;
    @(posedge clk_i);
    wait_exec_i <= 1'b1;
    @(posedge clk_i);
    wait_exec_i <= 1'b0;
  endtask
  task automatic t_cross;
    rdchk(STW_OFF_STATUS, 32'h1);
    rdchk(4'h6, 32'h0);
    wb(1'b1, STW_OFF_DETECT, 32'h1);
    rdchk(STW_OFF_STATUS, 32'h0);
    wb(1'b1, STW_OFF_IRQ, 32'h1);
    supply(1'b1);
    wait_out(3'b100, 8);
    hold(3'b100, 4);
    wait_out(3'b000, 12);
    rdchk(STW_OFF_IRQ, 32'h5);
    supply(1'b0);
    hold(3'b000, 6);
    wb(1'b1, STW_OFF_IRQ, 32'h5);
    rdchk(STW_OFF_IRQ, 32'h5);
    wb(1'b1, STW_OFF_IRQ, 32'h1);
    rdchk(STW_OFF_IRQ, 32'h1);
  endtask
  task automatic t_stop;
    wb(1'b1, STW_OFF_IRQ, 32'h3);
    wb(1'b1, STW_OFF_CLOCK, 32'h1);
    hold(3'b010, 6);
    supply(1'b1);
    wait_out(3'b100, 8);
    wait_out(3'b000, 12);
    rdchk(STW_OFF_CLOCK, 32'h0);
    wb(1'b1, STW_OFF_CLOCK, 32'h1);
    hold(3'b010, 6);
    rdchk(STW_OFF_CLOCK, 32'h1);
    wb(1'b1, STW_OFF_IRQ, 32'h5);
    wb(1'b1, STW_OFF_IRQ, 32'h7);
    wait_out(3'b100, 8);
    wait_out(3'b000, 12);
    rdchk(STW_OFF_IRQ, 32'h7);
  endtask
  task automatic t_wait;
    pulse_wait;
    wait_out(3'b100, 4);
    wait_out(3'b000, 12);
    supply(1'b0);
    hold(3'b000, 6);
    wb(1'b1, STW_OFF_IRQ, 32'h3);
    pulse_wait;
    hold(3'b001, 6);
    supply(1'b1);
    wait_out(3'b100, 8);
    ack_dly <= 4'h1;
    wait_out(3'b000, 6);
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_cross;
    t_stop;
    t_wait;
    summarize;
  end
  // watchdog
  initial begin
    repeat (4000) @(posedge clk_i);
    n_mismatch++;
    summarize;
  end
endmodule // test_stw_wake
